/* design/stw_defines.svh */
`ifndef STW_DEFINES_SVH
`define STW_DEFINES_SVH
// ------------------------------------------------------------
// Controller register offsets and fields
// ------------------------------------------------------------
`define STW_REG_CTRL 8'h00
`define STW_REG_STAT 8'h04
`define STW_REG_CDB0 8'h08
`define STW_REG_CDB1 8'h0C
`define STW_REG_CDB2 8'h10
`define STW_REG_WPTR 8'h14
`define STW_REG_WDAT 8'h18
`define STW_REG_IRQ_STAT 8'h1C
`define STW_REG_IRQ_EN 8'h20
`define STW_REG_IRQ_CLR 8'h24
`define STW_CTRL_START 0
`define STW_CTRL_TID 4
`define STW_CTRL_IDENT 8
`define STW_IRQ_DONE 0
`define STW_IRQ_CHECK 1
`define STW_IRQ_SELTO 2
// ------------------------------------------------------------
// Bus phase codes as {msg, cd, io}
// ------------------------------------------------------------
`define STW_PH_DOUT 3'h0
`define STW_PH_DIN 3'h1
`define STW_PH_CMD 3'h2
`define STW_PH_STAT 3'h3
`define STW_PH_MSGO 3'h6
`define STW_PH_MSGI 3'h7
// ------------------------------------------------------------
// Commands, status, sense, messages
// ------------------------------------------------------------
`define STW_OP_READY 8'h00
`define STW_OP_DIAG 8'h1D
`define STW_OP_SETWIN 8'h24
`define STW_B1_PAGEFMT 4
`define STW_B1_SELFTEST 2
`define STW_B1_UNITOFF 0
`define STW_ST_GOOD 5'h00
`define STW_ST_CHECK 5'h01
`define STW_SK_NONE 4'h0
`define STW_SK_NREADY 4'h2
`define STW_SK_ILLEGAL 4'h5
`define STW_ASC_NONE 8'h00
`define STW_ASC_BADCMD 8'h20
`define STW_ASC_BADCDB 8'h24
`define STW_ASC_BADPAR 8'h26
`define STW_MSG_DONE 8'h00
`define STW_MSG_IDENT 8'h80
// ------------------------------------------------------------
// Window data limits and header positions
// ------------------------------------------------------------
`define STW_WIN_MIN 24'h000030
`define STW_WDBL_MIN 16'h0028
`define STW_WDBL_MAX 16'h00F8
`define STW_WH_WDBL_HI 24'h000006
`define STW_WH_WDBL_LO 24'h000007
`define STW_WH_WID 24'h000008
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define STW_CLK_NS 10
`define STW_ARB_NS 240
`define STW_ARB_CYC ((`STW_ARB_NS + `STW_CLK_NS - 1) / `STW_CLK_NS)
`define STW_SEL_TO_NS 1000000
`define STW_SEL_TO_CYC (`STW_SEL_TO_NS / `STW_CLK_NS)
`endif

/* design/stw_pkg.sv */
package stw_pkg;
  typedef logic [7:0] stw_byte_t;
  typedef enum logic [3:0] {T_IDLE, T_SELW, T_MSGO, T_CMD, T_EXEC, T_DOUT, T_WCHK,
    T_STAT, T_MSGI} stw_tstate_e;
  typedef enum logic [1:0] {I_IDLE, I_ARB, I_SEL, I_XFER} stw_istate_e;
endpackage

/* design/stw_bus_if.sv */
`timescale 1ns/1ps
interface stw_bus_if;
  logic ini_bsy;
  logic sel;
  logic atn;
  logic ack;
  logic [7:0] ini_db_o;
  logic ini_db_oe;
  logic tgt_bsy;
  logic req;
  logic msg;
  logic cd;
  logic io;
  logic [7:0] tgt_db_o;
  logic tgt_db_oe;
  logic bsy;
  logic [7:0] db;
  // Wired-or busy; target wins the data lines when both drive
  assign bsy = ini_bsy | tgt_bsy;
  assign db = tgt_db_oe ? tgt_db_o : (ini_db_oe ? ini_db_o : 8'h00);
  modport tgt (input ini_bsy, sel, atn, ack, bsy, db,
    output tgt_bsy, req, msg, cd, io, tgt_db_o, tgt_db_oe);
  modport ini (input tgt_bsy, req, msg, cd, io, bsy, db,
    output ini_bsy, sel, atn, ack, ini_db_o, ini_db_oe);
endinterface

/* design/stw_target.sv */
`timescale 1ns/1ps
`include "stw_defines.svh"
// ------------------------------------------------------------
// What this block does
// RULE1 - Diagnostic runs select, message, command, status, message
// RULE2 - Only self-contained self-test form is accepted
// RULE3 - Page format bit is ignored
// RULE4 - Initiator sets self-test request bit to one
// RULE5 - Device and unit offline bits are ignored
// RULE6 - No parameter data phase for diagnostic
// RULE7 - Self-test is no-op except pending error
// RULE8 - No pending error gives GOOD, no sense
// RULE9 - Pending error gives CHECK with held sense
// RULE10 - Ready unit answers GOOD, no sense; with an error pending, the held sense is kept
// RULE11 - Unready unit answers CHECK, not ready
// RULE12 - Readiness probe has no data phase
// RULE13 - Window command takes data out phase
// RULE14 - Every CHECK builds matching sense data
// ------------------------------------------------------------
module stw_target #(
  parameter int WIN_DEPTH = 256
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  stw_bus_if.tgt BUS,
  input wire logic [2:0] TARGET_ID,
  input wire logic UNIT_READY,
  input wire logic ERR_EVT,
  input wire logic [3:0] ERR_KEY,
  input wire stw_pkg::stw_byte_t ERR_ASC,
  input wire stw_pkg::stw_byte_t ERR_ASCQ,
  output logic ERR_PENDING,
  output logic [3:0] SENSE_KEY,
  output stw_pkg::stw_byte_t SENSE_ASC,
  output stw_pkg::stw_byte_t SENSE_ASCQ,
  output logic CMD_DONE,
  output logic [4:0] LAST_STATUS,
  output logic WIN_VALID,
  output logic [23:0] WIN_BYTES,
  input wire logic [$clog2(WIN_DEPTH)-1:0] WIN_RD_ADDR,
  output stw_pkg::stw_byte_t WIN_RD_DATA
);
  import stw_pkg::*;

  stw_tstate_e state_r;
  stw_tstate_e state_nxt;
  logic req_r;
  stw_byte_t dout_r;
  logic [3:0] cnt_r;
  stw_byte_t cdb_r [10];
  logic [23:0] dcnt_r;
  logic [15:0] wdbl_r;
  stw_byte_t wid_r;
  stw_byte_t win_mem [WIN_DEPTH];
  logic [4:0] stat_r;
  logic pend_r;
  logic [19:0] sense_r;
  logic take;
  logic sel_hit;
  logic xfer;
  logic [2:0] ph;
  logic [3:0] cmd_last;
  logic [23:0] wlen;
  logic ev_ld;
  logic go_dout;
  logic [20:0] ev_res;

  // Group 1 and 2 opcodes carry ten-byte blocks
  function automatic logic [3:0] cdb_len(input stw_byte_t op);
    cdb_len = (op[7:5] == 3'h1 || op[7:5] == 3'h2) ? 4'hA : 4'h6;
  endfunction

  function automatic logic [20:0] check_of(input logic [3:0] key, input stw_byte_t asc);
    check_of = {1'h1, key, asc, 8'h00};
  endfunction

  // ------------------------------------------------------------
  // Bus phase sequencing
  // ------------------------------------------------------------
  assign take = req_r && BUS.ack;
  assign sel_hit = BUS.sel && !BUS.ini_bsy && BUS.db[TARGET_ID];
  assign cmd_last = cdb_len((cnt_r == 4'h0) ? BUS.db : cdb_r[0]) - 4'h1;
  assign wlen = {cdb_r[6], cdb_r[7], cdb_r[8]};

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      T_IDLE: if (sel_hit) state_nxt = T_SELW; // RULE1
      T_SELW: if (!BUS.sel) state_nxt = BUS.atn ? T_MSGO : T_CMD; // RULE13
      T_MSGO: if (take) state_nxt = T_CMD; // RULE1
      T_CMD: if (take && cnt_r == cmd_last) state_nxt = T_EXEC;
      T_EXEC: state_nxt = go_dout ? T_DOUT : T_STAT; // RULE6 RULE12
      T_DOUT: if (take && dcnt_r == wlen - 24'h1) state_nxt = T_WCHK; // RULE13
      T_WCHK: state_nxt = T_STAT;
      T_STAT: if (take) state_nxt = T_MSGI; // RULE1
      T_MSGI: if (take) state_nxt = T_IDLE; // RULE1 RULE12
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      state_r <= T_IDLE;
    else
      state_r <= state_nxt;
  end

  assign ph = (state_r == T_MSGO) ? `STW_PH_MSGO : (state_r == T_CMD) ? `STW_PH_CMD :
    (state_r == T_STAT) ? `STW_PH_STAT : (state_r == T_MSGI) ? `STW_PH_MSGI : `STW_PH_DOUT;

  assign xfer = state_r inside {T_MSGO, T_CMD, T_DOUT, T_STAT, T_MSGI};
  // Busy held from selection until the completion byte is taken
  assign BUS.tgt_bsy = state_r != T_IDLE; // RULE1 RULE12
  assign BUS.req = req_r;
  assign BUS.msg = ph[2];
  assign BUS.cd = ph[1];
  assign BUS.io = ph[0];
  assign BUS.tgt_db_o = dout_r;
  assign BUS.tgt_db_oe = ph[0];

  // ------------------------------------------------------------
  // Byte handshake
  // ------------------------------------------------------------
  // New request waits for ack low, so a slow initiator never double-counts
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      req_r <= 1'h0;
      dout_r <= 8'h00;
    end
    else if (take)
      req_r <= 1'h0;
    else if (xfer && !req_r && !BUS.ack)
    begin
      req_r <= 1'h1;
      dout_r <= (state_r == T_STAT) ? {2'h0, stat_r, 1'h0} : `STW_MSG_DONE;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      cnt_r <= 4'h0;
      dcnt_r <= 24'h0;
      wdbl_r <= 16'h0;
      wid_r <= 8'h00;
      for (int i = 0; i < 10; i++)
        cdb_r[i] <= 8'h00;
    end
    else
    begin
      if (state_r == T_SELW)
        cnt_r <= 4'h0;
      else if (take && state_r == T_CMD)
      begin
        cdb_r[cnt_r] <= BUS.db;
        cnt_r <= cnt_r + 4'h1;
      end
      if (state_r == T_EXEC)
        dcnt_r <= 24'h0;
      else if (take && state_r == T_DOUT)
      begin
        dcnt_r <= dcnt_r + 24'h1;
        if (dcnt_r == `STW_WH_WDBL_HI)
          wdbl_r[15:8] <= BUS.db;
        if (dcnt_r == `STW_WH_WDBL_LO)
          wdbl_r[7:0] <= BUS.db;
        if (dcnt_r == `STW_WH_WID)
          wid_r <= BUS.db;
      end
    end
  end

  // Bytes beyond the buffer depth are accepted and dropped
  always_ff @(posedge CORE_CLK)
  begin
    if (take && state_r == T_DOUT && dcnt_r < 24'(WIN_DEPTH))
      win_mem[dcnt_r[$clog2(WIN_DEPTH)-1:0]] <= BUS.db; // RULE13
    WIN_RD_DATA <= win_mem[WIN_RD_ADDR];
  end

  // ------------------------------------------------------------
  // Command evaluation
  // ------------------------------------------------------------
  always_comb
  begin
    ev_ld = 1'h0;
    go_dout = 1'h0;
    ev_res = 21'h0;
    if (state_r == T_EXEC)
    begin
      ev_ld = 1'h1;
      case (cdb_r[0])
        `STW_OP_DIAG:
          // Page format, offline bits and list length are never looked at
          if (!cdb_r[1][`STW_B1_SELFTEST]) // RULE2 RULE3 RULE5 RULE6
            ev_res = check_of(`STW_SK_ILLEGAL, `STW_ASC_BADCDB);
          else if (pend_r) // RULE7
            ev_res = {1'h1, sense_r}; // RULE9
        `STW_OP_READY:
          if (!UNIT_READY) // RULE10
            ev_res = check_of(`STW_SK_NREADY, `STW_ASC_NONE); // RULE11
        `STW_OP_SETWIN:
          if (wlen != 24'h0 && wlen < `STW_WIN_MIN)
            ev_res = check_of(`STW_SK_ILLEGAL, `STW_ASC_BADCDB);
          else if (wlen != 24'h0)
          begin
            ev_ld = 1'h0;
            go_dout = 1'h1; // RULE13
          end
        default:
          ev_res = check_of(`STW_SK_ILLEGAL, `STW_ASC_BADCMD);
      endcase
    end
    else if (state_r == T_WCHK)
    begin
      ev_ld = 1'h1;
      if (wdbl_r < `STW_WDBL_MIN || wdbl_r > `STW_WDBL_MAX || wid_r != 8'h00)
        ev_res = check_of(`STW_SK_ILLEGAL, `STW_ASC_BADPAR);
    end
  end

  // ------------------------------------------------------------
  // Status and sense
  // ------------------------------------------------------------
  // A new error outranks the clear of the same cycle
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      pend_r <= 1'h0;
      sense_r <= 20'h0;
    end
    else if (ERR_EVT)
    begin
      pend_r <= 1'h1;
      sense_r <= {ERR_KEY, ERR_ASC, ERR_ASCQ};
    end
    else if (ev_ld && (ev_res[20] || !pend_r)) // RULE14 RULE8
    begin
      pend_r <= 1'h0;
      sense_r <= ev_res[19:0];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      stat_r <= `STW_ST_GOOD;
      CMD_DONE <= 1'h0;
      LAST_STATUS <= `STW_ST_GOOD;
      WIN_VALID <= 1'h0;
      WIN_BYTES <= 24'h0;
    end
    else
    begin
      if (ev_ld)
        stat_r <= ev_res[20] ? `STW_ST_CHECK : `STW_ST_GOOD; // RULE8 RULE9 RULE10 RULE11
      CMD_DONE <= take && state_r == T_MSGI;
      if (take && state_r == T_MSGI)
        LAST_STATUS <= stat_r;
      // Old window is discarded as soon as new data starts
      if (go_dout)
        WIN_VALID <= 1'h0;
      else if (state_r == T_WCHK && !ev_res[20])
      begin
        WIN_VALID <= 1'h1;
        WIN_BYTES <= wlen;
      end
    end
  end

  assign ERR_PENDING = pend_r;
  assign {SENSE_KEY, SENSE_ASC, SENSE_ASCQ} = sense_r;
endmodule

/* design/stw_initiator.sv */
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "stw_defines.svh"
module stw_initiator #(
  parameter int WBUF_DEPTH = 256,
  parameter int SEL_TO_CYC = `STW_SEL_TO_CYC,
  parameter logic [2:0] OWN_ID = 3'h7
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  stw_bus_if.ini BUS,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);
  import stw_pkg::*;
  localparam int AW = $clog2(WBUF_DEPTH);

  stw_istate_e state_r;
  logic go_r;
  logic [2:0] tid_r;
  logic ident_r;
  logic [31:0] cdb_r [3];
  logic [AW-1:0] wptr_r;
  stw_byte_t wbuf [WBUF_DEPTH];
  logic [AW-1:0] dptr_r;
  logic [3:0] cptr_r;
  logic [31:0] tmr_r;
  logic ack_r;
  logic atn_r;
  stw_byte_t db_o_r;
  stw_byte_t st_byte_r;
  stw_byte_t msg_byte_r;
  logic selto_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_en_r;
  logic wr;
  logic [2:0] phase;
  logic fin;
  logic to_hit;
  stw_byte_t tx_byte;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = a inside {`STW_REG_CTRL, `STW_REG_STAT, `STW_REG_CDB0, `STW_REG_CDB1,
      `STW_REG_CDB2, `STW_REG_WPTR, `STW_REG_WDAT, `STW_REG_IRQ_STAT, `STW_REG_IRQ_EN,
      `STW_REG_IRQ_CLR};
  endfunction

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // Zero wait states: read data is registered in the setup cycle
  assign wr = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'h1;
  assign PSLVERR = PSEL && PENABLE && !reg_hit(PADDR);

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      PRDATA <= 32'h0;
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      case (PADDR)
        `STW_REG_CTRL: PRDATA <= {23'h0, ident_r, 1'h0, tid_r, 4'h0};
        `STW_REG_STAT: PRDATA <= {7'h0, selto_r, msg_byte_r, st_byte_r, 7'h0,
          state_r != I_IDLE || go_r};
        `STW_REG_CDB0: PRDATA <= cdb_r[0];
        `STW_REG_CDB1: PRDATA <= cdb_r[1];
        `STW_REG_CDB2: PRDATA <= cdb_r[2];
        `STW_REG_WPTR: PRDATA <= 32'(wptr_r);
        `STW_REG_IRQ_STAT: PRDATA <= {29'h0, irq_st_r};
        `STW_REG_IRQ_EN: PRDATA <= {29'h0, irq_en_r};
        default: PRDATA <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      tid_r <= 3'h0;
      ident_r <= 1'h1;
      wptr_r <= '0;
      irq_en_r <= 3'h0;
      for (int i = 0; i < 3; i++)
        cdb_r[i] <= 32'h0;
    end
    else if (wr)
    begin
      case (PADDR)
        `STW_REG_CTRL:
        begin
          tid_r <= PWDATA[`STW_CTRL_TID +: 3];
          ident_r <= PWDATA[`STW_CTRL_IDENT];
        end
        `STW_REG_CDB0: cdb_r[0] <= PWDATA;
        `STW_REG_CDB1: cdb_r[1] <= PWDATA;
        `STW_REG_CDB2: cdb_r[2] <= PWDATA;
        `STW_REG_WPTR: wptr_r <= PWDATA[AW-1:0];
        `STW_REG_WDAT: wptr_r <= wptr_r + 1'h1;
        `STW_REG_IRQ_EN: irq_en_r <= PWDATA[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (wr && PADDR == `STW_REG_WDAT)
      wbuf[wptr_r] <= PWDATA[7:0];
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  assign fin = (state_r == I_XFER && !BUS.bsy && !ack_r) || to_hit;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      irq_st_r <= 3'h0;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr && PADDR == `STW_REG_IRQ_CLR && PWDATA[i])
          irq_st_r[i] <= 1'h0;
      end
      // Set is written last so it wins over a clear in the same cycle
      if (fin)
        irq_st_r[`STW_IRQ_DONE] <= 1'h1;
      if (fin && !to_hit && st_byte_r[5:1] != `STW_ST_GOOD)
        irq_st_r[`STW_IRQ_CHECK] <= 1'h1;
      if (to_hit)
        irq_st_r[`STW_IRQ_SELTO] <= 1'h1;
    end
  end

  assign IRQ = |(irq_st_r & irq_en_r);

  // ------------------------------------------------------------
  // Bus sequencing
  // ------------------------------------------------------------
  assign phase = {BUS.msg, BUS.cd, BUS.io};
  assign to_hit = state_r == I_SEL && !BUS.bsy && tmr_r == 32'(SEL_TO_CYC - 1);

  always_comb
  begin
    tx_byte = 8'h00;
    unique case (phase)
      `STW_PH_MSGO: tx_byte = `STW_MSG_IDENT; // RULE1
      `STW_PH_CMD: tx_byte = cdb_r[cptr_r[3:2]][{cptr_r[1:0], 3'h0} +: 8];
      `STW_PH_DOUT: tx_byte = wbuf[dptr_r]; // RULE13
      default: tx_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state_r <= I_IDLE;
      go_r <= 1'h0;
      tmr_r <= 32'h0;
      ack_r <= 1'h0;
      atn_r <= 1'h0;
      db_o_r <= 8'h00;
      cptr_r <= 4'h0;
      dptr_r <= '0;
      st_byte_r <= 8'h00;
      msg_byte_r <= 8'h00;
      selto_r <= 1'h0;
    end
    else
    begin
      unique case (state_r)
        I_IDLE:
        begin
          // Starts only on a free bus
          if (go_r && !BUS.bsy && !BUS.sel) // RULE1
          begin
            state_r <= I_ARB;
            go_r <= 1'h0;
            tmr_r <= 32'h0;
            db_o_r <= 8'h01 << OWN_ID;
            cptr_r <= 4'h0;
            dptr_r <= '0;
            selto_r <= 1'h0;
          end
        end
        I_ARB:
        begin
          tmr_r <= tmr_r + 32'h1;
          if (tmr_r == 32'(`STW_ARB_CYC - 1))
          begin
            state_r <= I_SEL;
            tmr_r <= 32'h0;
            atn_r <= ident_r; // RULE13
            db_o_r <= (8'h01 << OWN_ID) | (8'h01 << tid_r);
          end
        end
        I_SEL:
        begin
          tmr_r <= tmr_r + 32'h1;
          if (BUS.bsy)
            state_r <= I_XFER; // RULE1
          else if (to_hit)
          begin
            state_r <= I_IDLE;
            atn_r <= 1'h0;
            selto_r <= 1'h1;
          end
        end
        I_XFER:
        begin
          if (ack_r && !BUS.req)
            ack_r <= 1'h0;
          else if (!ack_r && BUS.req)
          begin
            ack_r <= 1'h1;
            db_o_r <= tx_byte;
            if (phase == `STW_PH_MSGO)
              atn_r <= 1'h0;
            if (phase == `STW_PH_CMD)
              cptr_r <= cptr_r + 4'h1;
            if (phase == `STW_PH_DOUT)
              dptr_r <= dptr_r + 1'h1;
            if (phase == `STW_PH_STAT)
              st_byte_r <= BUS.db;
            if (phase == `STW_PH_MSGI)
              msg_byte_r <= BUS.db;
          end
          else if (!BUS.bsy && !ack_r)
            state_r <= I_IDLE;
        end
      endcase
      // Written last so a start in the launch cycle stays queued
      if (wr && PADDR == `STW_REG_CTRL && PWDATA[`STW_CTRL_START])
        go_r <= 1'h1;
    end
  end

  assign BUS.ini_bsy = state_r == I_ARB;
  assign BUS.sel = state_r == I_SEL;
  assign BUS.atn = atn_r;
  assign BUS.ack = ack_r;
  assign BUS.ini_db_o = db_o_r;
  assign BUS.ini_db_oe = state_r inside {I_ARB, I_SEL} || (state_r == I_XFER && ack_r && !BUS.io);
endmodule

/* verif/stw_bus_checker.sv */
`timescale 1ns/1ps
`include "stw_defines.svh"
// ----------------------------------------
// Wire protocol checker
// ----------------------------------------
module stw_bus_checker (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic tgt_bsy,
  input wire logic req,
  input wire logic ack,
  input wire logic msg,
  input wire logic cd,
  input wire logic io,
  input wire logic [7:0] db
);
  logic [2:0] ph;
  logic [7:0] op_r;
  logic first_r;
  logic msgi_r;
  assign ph = {msg, cd, io};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Opcode is the first command byte of a connection
  always_ff @(posedge CORE_CLK)
    if (RST || !tgt_bsy)
      first_r <= 1'b1;
    else if (ph == `STW_PH_CMD && req && ack)
      first_r <= 1'b0;
  always_ff @(posedge CORE_CLK)
    if (RST || !tgt_bsy)
      op_r <= 8'h00;
    else if (ph == `STW_PH_CMD && req && ack && first_r)
      op_r <= db;
  // Release is only legal once completion was handed over
  always_ff @(posedge CORE_CLK)
    if (RST || !tgt_bsy)
      msgi_r <= 1'b0;
    else if (ph == `STW_PH_MSGI && req && ack)
      msgi_r <= 1'b1;
  a_req_stands: assert property (req && !ack |=> req)
    else $error("byte request dropped before acknowledge");
  a_ack_answers: assert property ($rose(req) |-> ##[1:2] ack)
    else $error("acknowledge late");
  a_ack_drops: assert property ($fell(req) |-> ##[0:2] !ack)
    else $error("acknowledge held too long");
  a_phase_busy: assert property (req |-> tgt_bsy && ph != `STW_PH_DIN)
    else $error("phase without busy or data-in seen");
  a_status_form: assert property (req && ph == `STW_PH_STAT |-> db[7:6] == 2'b00
    && !db[0] && db[5:1] inside {`STW_ST_GOOD, `STW_ST_CHECK})
    else $error("bad status byte");
  a_msgin_done: assert property (req && ph == `STW_PH_MSGI |-> db == `STW_MSG_DONE)
    else $error("bad message-in byte");
  a_dout_setwin: assert property (req && ph == `STW_PH_DOUT |-> op_r == `STW_OP_SETWIN)
    else $error("data-out for wrong command");
  a_bsy_release: assert property ($fell(tgt_bsy) |-> msgi_r)
    else $error("busy released before completion");
  c_data_out: cover property (req && ph == `STW_PH_DOUT);
  c_check: cover property (req && ph == `STW_PH_STAT && db[5:1] == `STW_ST_CHECK);
  c_release: cover property ($fell(tgt_bsy));
endmodule

/* verif/scsi_target_diag_ready_window_cmds_tb.sv */
`timescale 1ns/1ps
`include "stw_defines.svh"
module scsi_target_diag_ready_window_cmds_tb;
  import stw_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, UNIT_READY = 1'b1, ERR_EVT = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0] ERR_KEY = 4'h0;
  stw_byte_t ERR_ASC = 8'h00, ERR_ASCQ = 8'h00, WIN_RD_DATA, SENSE_ASC, SENSE_ASCQ;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, IRQ, ERR_PENDING, CMD_DONE, WIN_VALID, er;
  logic [3:0] SENSE_KEY;
  logic [4:0] LAST_STATUS;
  logic [23:0] WIN_BYTES;
  int fail_count = 0;
  int comparisons = 0;
  int done_count = 0;
  stw_bus_if bus ();
  stw_initiator #(.SEL_TO_CYC(50)) i_stw_initiator (.CORE_CLK(CORE_CLK), .RST(RST),
    .BUS(bus), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
  stw_target i_stw_target (.CORE_CLK(CORE_CLK), .RST(RST), .BUS(bus), .TARGET_ID(3'h2),
    .UNIT_READY(UNIT_READY), .ERR_EVT(ERR_EVT), .ERR_KEY(ERR_KEY), .ERR_ASC(ERR_ASC),
    .ERR_ASCQ(ERR_ASCQ), .ERR_PENDING(ERR_PENDING), .SENSE_KEY(SENSE_KEY),
    .SENSE_ASC(SENSE_ASC), .SENSE_ASCQ(SENSE_ASCQ), .CMD_DONE(CMD_DONE),
    .LAST_STATUS(LAST_STATUS), .WIN_VALID(WIN_VALID), .WIN_BYTES(WIN_BYTES),
    .WIN_RD_ADDR(8'h2F), .WIN_RD_DATA(WIN_RD_DATA));
  stw_bus_checker i_stw_bus_checker (.CORE_CLK(CORE_CLK), .RST(RST), .tgt_bsy(bus.tgt_bsy),
    .req(bus.req), .ack(bus.ack), .msg(bus.msg), .cd(bus.cd), .io(bus.io), .db(bus.db));
  always #5 CORE_CLK = ~CORE_CLK;
  // One completion pulse per finished command
  always @(posedge CORE_CLK)
    if (CMD_DONE === 1'b1)
      done_count++;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Request held until the edge that samples ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1)
    begin
      chk(1'b0, 1'b1);
      close_out();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // One full command; polling is bounded so a hung link ends the run
  task run(input logic [31:0] c0, c1, c2, input logic idn, input logic [4:0] st);
    int n;
    n = 0;
    apb(1'b1, `STW_REG_IRQ_CLR, 32'h7);
    apb(1'b1, `STW_REG_CDB0, c0);
    apb(1'b1, `STW_REG_CDB1, c1);
    apb(1'b1, `STW_REG_CDB2, c2);
    apb(1'b1, `STW_REG_CTRL, {23'h0, idn, 1'b0, 3'h2, 4'h1});
    do
    begin
      apb(1'b0, `STW_REG_IRQ_STAT, 32'h0);
      n++;
    end
    while (rd[`STW_IRQ_DONE] !== 1'b1 && n < 500);
    if (rd[`STW_IRQ_DONE] !== 1'b1)
    begin
      chk(1'b0, 1'b1);
      close_out();
    end
    apb(1'b0, `STW_REG_STAT, 32'h0);
    chk(rd[15:8], {2'b00, st, 1'b0});
    chk(rd[23:16], `STW_MSG_DONE);
    chk(LAST_STATUS, st);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'b0;
    apb(1'b0, `STW_REG_CTRL, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, 8'hFC, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, `STW_REG_IRQ_EN, 32'h3);
    run(32'h0, 32'h0, 32'h0, 1'b1, `STW_ST_GOOD);
    chk({SENSE_KEY, SENSE_ASC, SENSE_ASCQ}, 20'h0);
    UNIT_READY <= 1'b0;
    run(32'h0, 32'h0, 32'h0, 1'b1, `STW_ST_CHECK);
    chk({SENSE_KEY, SENSE_ASC, SENSE_ASCQ}, 20'h20000);
    #1;
    chk(IRQ, 1'b1);
    apb(1'b1, `STW_REG_IRQ_EN, 32'h0);
    #1;
    chk(IRQ, 1'b0);
    apb(1'b1, `STW_REG_IRQ_CLR, 32'h7);
    apb(1'b0, `STW_REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    // Offline, page format and list length set: all must be ignored
    run(32'h1200171D, 32'h34, 32'h0, 1'b1, `STW_ST_GOOD);
    chk({SENSE_KEY, SENSE_ASC, SENSE_ASCQ}, 20'h0);
    run(32'h0000001D, 32'h0, 32'h0, 1'b1, `STW_ST_CHECK);
    chk({SENSE_KEY, SENSE_ASC, SENSE_ASCQ}, 20'h52400);
    @(posedge CORE_CLK);
    ERR_EVT <= 1'b1;
    ERR_KEY <= 4'h3;
    ERR_ASC <= 8'h80;
    ERR_ASCQ <= 8'h01;
    @(posedge CORE_CLK);
    ERR_EVT <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    chk(ERR_PENDING, 1'b1);
    run(32'h0000041D, 32'h0, 32'h0, 1'b1, `STW_ST_CHECK);
    chk({SENSE_KEY, SENSE_ASC, SENSE_ASCQ}, 20'h38001);
    chk(ERR_PENDING, 1'b0);
    // Window data without message out: 8 header bytes and one 40-byte block
    apb(1'b1, `STW_REG_WPTR, 32'h0);
    for (int i = 0; i < 48; i++)
      apb(1'b1, `STW_REG_WDAT, (i == 7) ? 32'h28 : ((i == 47) ? 32'hA5 : 32'h0));
    run(32'h24, 32'h0, 32'h30, 1'b0, `STW_ST_GOOD);
    chk({WIN_VALID, WIN_BYTES}, 25'h1000030);
    chk(WIN_RD_DATA, 8'hA5);
    run(32'h24, 32'h0, 32'h10, 1'b0, `STW_ST_CHECK);
    chk({SENSE_KEY, SENSE_ASC, SENSE_ASCQ}, 20'h52400);
    run(32'h1B, 32'h0, 32'h0, 1'b1, `STW_ST_CHECK);
    chk({SENSE_KEY, SENSE_ASC, SENSE_ASCQ}, 20'h52000);
    // Descriptor length 16 is below the legal range
    apb(1'b1, `STW_REG_WPTR, 32'h7);
    apb(1'b1, `STW_REG_WDAT, 32'h10);
    run(32'h24, 32'h0, 32'h30, 1'b0, `STW_ST_CHECK);
    chk({SENSE_KEY, SENSE_ASC, SENSE_ASCQ}, 20'h52600);
    chk(WIN_VALID, 1'b0);
    chk(done_count, 32'h9);
    close_out();
  end
endmodule
